// ### rtl/pmx_pkg.sv
package pmx_pkg;

  localparam int P1_PINS  = 3;
  localparam int P2_PINS  = 8;
  localparam int P3_PINS  = 4;
  localparam int NUM_PINS = 15;
  localparam int P1_BASE  = 0;
  localparam int P2_BASE  = 3;
  localparam int P3_BASE  = 11;
  localparam int EDGE_CH  = 4;

  // pin indices inside the 15-bit pad vectors
  localparam int PIN_SCLK   = 0;
  localparam int PIN_RXD    = 1;
  localparam int PIN_TXD    = 2;
  localparam int PIN_IRQ_E  = 11;
  localparam int PIN_IRQ_C  = 12;
  localparam int PIN_IRQ_B  = 14;

  // register byte offsets
  localparam logic [7:0] OFS_P1_DIR    = 8'h00;
  localparam logic [7:0] OFS_P1_PULL   = 8'h04;
  localparam logic [7:0] OFS_P1_FUNC   = 8'h08;
  localparam logic [7:0] OFS_P1_CTRL   = 8'h0C;
  localparam logic [7:0] OFS_P2_DIR    = 8'h10;
  localparam logic [7:0] OFS_P2_FUNC   = 8'h14;
  localparam logic [7:0] OFS_P2_ANALOG = 8'h18;
  localparam logic [7:0] OFS_P3_DIR    = 8'h1C;
  localparam logic [7:0] OFS_P3_PULL   = 8'h20;
  localparam logic [7:0] OFS_P3_CTRL   = 8'h24;
  localparam logic [7:0] OFS_EDGE_CFG  = 8'h28;
  localparam logic [7:0] OFS_OUT_LATCH = 8'h2C;
  localparam logic [7:0] OFS_PIN_LEVEL = 8'h30;
  localparam logic [7:0] OFS_MISC      = 8'h34;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h38;
  localparam logic [7:0] OFS_IRQ_CLR   = 8'h3C;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h40;

  // reset values; direction bit 1 means input
  localparam logic [2:0]  RST_P1_DIR    = 3'h7;
  localparam logic [7:0]  RST_P2_DIR    = 8'hFF;
  localparam logic [7:0]  RST_P2_ANALOG = 8'hFF;
  localparam logic [3:0]  RST_P3_DIR    = 4'hF;
  localparam logic [5:0]  RST_EDGE_CFG  = 6'h00;
  localparam logic [14:0] RST_LATCH     = 15'h0000;
  localparam logic [1:0]  RST_ZC_OE     = 2'h3;
  localparam logic        RST_RTC_OE    = 1'b1;

  typedef enum logic [1:0] {
    PMX_TX_SERIAL   = 2'b00,
    PMX_TX_UART     = 2'b01,
    PMX_TX_INFRARED = 2'b10
  } pmx_txsel_type;

  typedef struct packed {
    logic out;
    logic oe;
    logic pull;
  } pmx_pad_type;

  typedef struct packed {
    logic       rtcSel;
    logic [1:0] lvLatch;
    logic [1:0] zcEn;
    logic [1:0] narrowEn;
  } pmx_misc_type;

endpackage

// ### rtl/pmx_pin_cell.sv
module pmx_pin_cell (
  input  wire logic               mclk,
  input  wire logic               rst_b,
  input  wire logic               padIn,
  input  wire pmx_pkg::pmx_pad_type drive,
  output pmx_pkg::pmx_pad_type    pad,
  output logic                    syncLevel
);

  logic syncA_q;
  logic syncB_q;

  // pad starts undriven with no pull until config reaches it
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      pad <= '0;
    else
      pad <= drive;
  end

  // first stage is read by the second stage only
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
    end
    else
    begin
      syncA_q <= padIn;
      syncB_q <= syncA_q;
    end
  end

  assign syncLevel = syncB_q;

endmodule // pmx_pin_cell

// ### rtl/pmx_edge_det.sv
module pmx_edge_det (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic level,
  input  wire logic riseEn,
  input  wire logic fallEn,
  output logic      risePulse,
  output logic      fallPulse
);

  logic prev_q;

  // a pin already high at reset release reads as one rising edge
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prev_q    <= 1'b0;
      risePulse <= 1'b0;
      fallPulse <= 1'b0;
    end
    else
    begin
      prev_q    <= level;
      risePulse <= riseEn & level & ~prev_q;
      fallPulse <= fallEn & ~level & prev_q;
    end
  end

endmodule // pmx_edge_det

// ### rtl/pmx_port_mux.sv
// Functional notes
// [RULE1] port 1 and 3 pins take direction from their own direction bit
// [RULE2] port 1 and 3 pull-ups follow the pull-up select register
// [RULE3] port 2 pin direction set per bit by its direction register
// [RULE4] port 2 chooses port or lcd segment; large package only
// [RULE5] port 2 pins are analog inputs after reset
// [RULE6] port 1 pin 3 source: serial out, uart transmit or infrared
// [RULE7] small package: port 1 pin 3 is output only
// [RULE8] each external irq input detects rising, falling or both edges
// [RULE9] wide timer input is count clock and trigger for both captures
// [RULE10] narrow timer pins stay input until software enables output
// [RULE11] zero-cross pins are outputs after reset, shared with port bits
// [RULE12] rtc pin drives 32 kHz after reset, or 1 Hz when selected
// [RULE13] control mode routes port 1 to sync serial and uart lines
// [RULE14] control mode pin drive comes from peripheral, not port latch
module pmx_port_mux #(
  parameter bit LARGE_PKG = 1'b1
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic [14:0] padIn,
  output logic [14:0]      padOut,
  output logic [14:0]      padOe,
  output logic [14:0]      padPullEn,
  input  wire logic        syncSerialClockOut,
  input  wire logic        syncSerialClockOe,
  output logic             syncSerialClockIn,
  output logic             syncSerialDataIn,
  input  wire logic        syncSerialDataOut,
  output logic             uartAReceive,
  input  wire logic        uartATransmit,
  input  wire logic        infraredDataOut,
  input  wire logic [7:0]  lcdSegmentOutputs,
  output logic [7:0]       analogInputSel,
  input  wire logic        hTimerAOutput,
  input  wire logic        hTimerBOutput,
  input  wire logic        buzzerOutput,
  output logic             extIrqInputB,
  output logic             extIrqInputC,
  output logic             extIrqInputE,
  output logic             wideTimerCountClk,
  output logic             wideTimerCaptureA,
  output logic             wideTimerCaptureB,
  input  wire logic [1:0]  narrowTimerOutput,
  output logic [1:0]       narrowPinOut,
  output logic [1:0]       narrowPinOe,
  input  wire logic [1:0]  zeroCrossIn,
  output logic [1:0]       zeroCrossPinOut,
  output logic [1:0]       zeroCrossPinOe,
  input  wire logic        rtcClock32k,
  input  wire logic        rtcCorrection1hz,
  output logic             rtcPinOut,
  output logic             rtcPinOe
);

  if (pmx_pkg::P1_PINS + pmx_pkg::P2_PINS + pmx_pkg::P3_PINS != pmx_pkg::NUM_PINS)
    $error("pin counts do not add up to the pad vector width");

  logic [2:0]                 port1DirectionBits_q;
  logic [2:0]                 port1PullupBits_q;
  pmx_pkg::pmx_txsel_type     port1FunctionSelect_q;
  logic [2:0]                 port1Ctrl_q;
  logic [7:0]                 port2DirectionBits_q;
  logic [7:0]                 port2FunctionSelect_q;
  logic [7:0]                 port2Analog_q;
  logic [3:0]                 port3DirectionBits_q;
  logic [3:0]                 port3PullupBits_q;
  logic [3:0]                 port3Ctrl_q;
  logic [5:0]                 edgeCfg_q;
  logic [14:0]                outLatch_q;
  pmx_pkg::pmx_misc_type      misc_q;
  logic [3:0]                 irqStatus_q;
  logic [3:0]                 irqEnable_q;
  logic                       ack_q;
  logic                       seen_q;
  logic [31:0]                rdMux;
  logic                       rdErr;
  logic                       wrEn;
  logic                       clrEn;
  logic [14:0]                pinSync;
  logic [14:0]                pinLevel;
  logic                       txMux;
  logic [7:0]                 lcdSel;
  logic [2:0]                 p1PerOut;
  logic [2:0]                 p1PerOe;
  logic [3:0]                 p3PerOut;
  logic [3:0]                 p3PerOe;
  logic [3:0]                 edgeLevel;
  logic [3:0]                 edgeRiseEn;
  logic [3:0]                 edgeFallEn;
  logic [3:0]                 edgeRise;
  logic [3:0]                 edgeFall;
  logic [3:0]                 events;
  pmx_pkg::pmx_pad_type       req [pmx_pkg::NUM_PINS];
  pmx_pkg::pmx_pad_type       pad [pmx_pkg::NUM_PINS];

  // apb: one wait state so read data comes from a flop
  assign pready = ack_q;
  assign wrEn   = psel & penable & pwrite & ack_q;
  assign clrEn  = wrEn & (paddr == pmx_pkg::OFS_IRQ_CLR);

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_q   <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      ack_q <= psel & penable & ~ack_q;
      if (psel & penable & ~ack_q)
      begin
        prdata  <= pwrite ? 32'h0000_0000 : rdMux;
        pslverr <= rdErr;
      end
    end
  end

  always_comb
  begin
    rdMux = 32'h0000_0000;
    rdErr = 1'b0;
    unique case (paddr)
      pmx_pkg::OFS_P1_DIR:    rdMux[2:0]  = port1DirectionBits_q;
      pmx_pkg::OFS_P1_PULL:   rdMux[2:0]  = port1PullupBits_q;
      pmx_pkg::OFS_P1_FUNC:   rdMux[1:0]  = port1FunctionSelect_q;
      pmx_pkg::OFS_P1_CTRL:   rdMux[2:0]  = port1Ctrl_q;
      pmx_pkg::OFS_P2_DIR:    rdMux[7:0]  = port2DirectionBits_q;
      pmx_pkg::OFS_P2_FUNC:   rdMux[7:0]  = port2FunctionSelect_q;
      pmx_pkg::OFS_P2_ANALOG: rdMux[7:0]  = port2Analog_q;
      pmx_pkg::OFS_P3_DIR:    rdMux[3:0]  = port3DirectionBits_q;
      pmx_pkg::OFS_P3_PULL:   rdMux[3:0]  = port3PullupBits_q;
      pmx_pkg::OFS_P3_CTRL:   rdMux[3:0]  = port3Ctrl_q;
      pmx_pkg::OFS_EDGE_CFG:  rdMux[5:0]  = edgeCfg_q;
      pmx_pkg::OFS_OUT_LATCH: rdMux[14:0] = outLatch_q;
      pmx_pkg::OFS_PIN_LEVEL: rdMux[14:0] = pinLevel;
      pmx_pkg::OFS_MISC:      rdMux[6:0]  = misc_q;
      pmx_pkg::OFS_IRQ_STAT:  rdMux[3:0]  = irqStatus_q;
      pmx_pkg::OFS_IRQ_CLR:   rdMux       = 32'h0000_0000;
      pmx_pkg::OFS_IRQ_EN:    rdMux[3:0]  = irqEnable_q;
      default:                rdErr       = 1'b1;
    endcase
  end

  // configuration registers
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      port1DirectionBits_q  <= pmx_pkg::RST_P1_DIR;
      port1PullupBits_q     <= 3'h0;
      port1FunctionSelect_q <= pmx_pkg::PMX_TX_SERIAL;
      port1Ctrl_q           <= 3'h0;
      port2DirectionBits_q  <= pmx_pkg::RST_P2_DIR;
      port2FunctionSelect_q <= 8'h00;
      port2Analog_q         <= pmx_pkg::RST_P2_ANALOG; // RULE5
      port3DirectionBits_q  <= pmx_pkg::RST_P3_DIR;
      port3PullupBits_q     <= 4'h0;
      port3Ctrl_q           <= 4'h0;
      edgeCfg_q             <= pmx_pkg::RST_EDGE_CFG;
      outLatch_q            <= pmx_pkg::RST_LATCH;
      misc_q                <= '0;
      irqEnable_q           <= 4'h0;
    end
    else if (wrEn)
    begin
      unique case (paddr)
        pmx_pkg::OFS_P1_DIR:    port1DirectionBits_q  <= pwdata[2:0];
        pmx_pkg::OFS_P1_PULL:   port1PullupBits_q     <= pwdata[2:0];
        pmx_pkg::OFS_P1_FUNC:   port1FunctionSelect_q <= pmx_pkg::pmx_txsel_type'(pwdata[1:0]);
        pmx_pkg::OFS_P1_CTRL:   port1Ctrl_q           <= pwdata[2:0];
        pmx_pkg::OFS_P2_DIR:    port2DirectionBits_q  <= pwdata[7:0];
        pmx_pkg::OFS_P2_FUNC:   port2FunctionSelect_q <= LARGE_PKG ? pwdata[7:0] : 8'h00; // RULE4
        pmx_pkg::OFS_P2_ANALOG: port2Analog_q         <= pwdata[7:0];
        pmx_pkg::OFS_P3_DIR:    port3DirectionBits_q  <= pwdata[3:0];
        pmx_pkg::OFS_P3_PULL:   port3PullupBits_q     <= pwdata[3:0];
        pmx_pkg::OFS_P3_CTRL:   port3Ctrl_q           <= pwdata[3:0];
        pmx_pkg::OFS_EDGE_CFG:  edgeCfg_q             <= pwdata[5:0];
        pmx_pkg::OFS_OUT_LATCH: outLatch_q            <= pwdata[14:0];
        pmx_pkg::OFS_MISC:      misc_q                <= pwdata[6:0];
        pmx_pkg::OFS_IRQ_EN:    irqEnable_q           <= pwdata[3:0];
        default:                irqEnable_q           <= irqEnable_q;
      endcase
    end
  end

  // sticky status: a new event beats a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irqStatus_q <= 4'h0;
      irq         <= 1'b0;
    end
    else
    begin
      irqStatus_q <= (irqStatus_q & ~(clrEn ? pwdata[3:0] : 4'h0)) | events;
      irq         <= |(irqStatus_q & irqEnable_q);
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      seen_q <= 1'b0;
    else
      seen_q <= 1'b1;
  end

  // peripheral sources per pin; unused sources tie low
  always_comb
  begin
    unique case (port1FunctionSelect_q) // RULE6
      pmx_pkg::PMX_TX_UART:     txMux = uartATransmit;
      pmx_pkg::PMX_TX_INFRARED: txMux = infraredDataOut;
      default:                  txMux = syncSerialDataOut;
    endcase
  end

  assign p1PerOut = {txMux, 1'b0, syncSerialClockOut}; // RULE13
  assign p1PerOe  = {1'b1, 1'b0, syncSerialClockOe};
  assign p3PerOut = {buzzerOutput, hTimerAOutput, hTimerBOutput, 1'b0};
  assign p3PerOe  = 4'b1110;
  assign lcdSel   = LARGE_PKG ? port2FunctionSelect_q : 8'h00;

  always_comb
  begin
    for (int i = 0; i < pmx_pkg::NUM_PINS; i++)
      req[i] = '0;
    for (int i = 0; i < pmx_pkg::P1_PINS; i++)
    begin
      req[pmx_pkg::P1_BASE + i].out  = outLatch_q[pmx_pkg::P1_BASE + i];
      req[pmx_pkg::P1_BASE + i].oe   = ~port1DirectionBits_q[i]; // RULE1
      req[pmx_pkg::P1_BASE + i].pull = port1PullupBits_q[i] & port1DirectionBits_q[i]
                                       & ~port1Ctrl_q[i]; // RULE2
      if (port1Ctrl_q[i])
      begin
        req[pmx_pkg::P1_BASE + i].out = p1PerOut[i]; // RULE14
        req[pmx_pkg::P1_BASE + i].oe  = p1PerOe[i];
      end
    end
    // small package: no input buffer and no pull-up on this pin
    if (!LARGE_PKG && !port1Ctrl_q[2])
    begin
      req[pmx_pkg::PIN_TXD].oe   = 1'b1; // RULE7
      req[pmx_pkg::PIN_TXD].pull = 1'b0;
    end
    for (int i = 0; i < pmx_pkg::P2_PINS; i++)
    begin
      req[pmx_pkg::P2_BASE + i].out = outLatch_q[pmx_pkg::P2_BASE + i];
      req[pmx_pkg::P2_BASE + i].oe  = ~port2DirectionBits_q[i]; // RULE3
      if (lcdSel[i])
      begin
        req[pmx_pkg::P2_BASE + i].out = lcdSegmentOutputs[i]; // RULE4
        req[pmx_pkg::P2_BASE + i].oe  = 1'b1;
      end
      if (port2Analog_q[i])
        req[pmx_pkg::P2_BASE + i].oe = 1'b0; // RULE5
    end
    for (int i = 0; i < pmx_pkg::P3_PINS; i++)
    begin
      req[pmx_pkg::P3_BASE + i].out  = outLatch_q[pmx_pkg::P3_BASE + i];
      req[pmx_pkg::P3_BASE + i].oe   = ~port3DirectionBits_q[i]; // RULE1
      req[pmx_pkg::P3_BASE + i].pull = port3PullupBits_q[i] & port3DirectionBits_q[i]
                                       & ~port3Ctrl_q[i]; // RULE2
      if (port3Ctrl_q[i])
      begin
        req[pmx_pkg::P3_BASE + i].out = p3PerOut[i]; // RULE14
        req[pmx_pkg::P3_BASE + i].oe  = p3PerOe[i];
      end
    end
  end

  for (genvar g = 0; g < pmx_pkg::NUM_PINS; g++)
  begin : gPin
    pmx_pin_cell uCell (
      .mclk      (mclk),
      .rst_b     (rst_b),
      .padIn     (padIn[g]),
      .drive     (req[g]),
      .pad       (pad[g]),
      .syncLevel (pinSync[g])
    );
    assign padOut[g]    = pad[g].out;
    assign padOe[g]     = pad[g].oe;
    assign padPullEn[g] = pad[g].pull;
  end

  // analog pins and the output-only pin read back as zero
  always_comb
  begin
    pinLevel = pinSync;
    pinLevel[pmx_pkg::P2_BASE +: pmx_pkg::P2_PINS] = pinSync[pmx_pkg::P2_BASE +: pmx_pkg::P2_PINS]
                                                     & ~port2Analog_q;
    if (!LARGE_PKG)
      pinLevel[pmx_pkg::PIN_TXD] = 1'b0;
  end

  assign syncSerialClockIn = pinSync[pmx_pkg::PIN_SCLK]; // RULE13
  assign syncSerialDataIn  = pinSync[pmx_pkg::PIN_RXD];
  assign uartAReceive      = pinSync[pmx_pkg::PIN_RXD];
  assign analogInputSel    = port2Analog_q;
  assign wideTimerCountClk = pinSync[pmx_pkg::PIN_IRQ_B]; // RULE9

  // channels: irq e, irq c, irq b, wide timer input on both edges
  assign edgeLevel  = {pinSync[pmx_pkg::PIN_IRQ_B], pinSync[pmx_pkg::PIN_IRQ_B],
                       pinSync[pmx_pkg::PIN_IRQ_C], pinSync[pmx_pkg::PIN_IRQ_E]};
  assign edgeRiseEn = {1'b1, edgeCfg_q[4], edgeCfg_q[2], edgeCfg_q[0]};
  assign edgeFallEn = {1'b1, edgeCfg_q[5], edgeCfg_q[3], edgeCfg_q[1]};

  for (genvar e = 0; e < pmx_pkg::EDGE_CH; e++)
  begin : gEdge
    pmx_edge_det uEdge (
      .mclk      (mclk),
      .rst_b     (rst_b),
      .level     (edgeLevel[e]),
      .riseEn    (edgeRiseEn[e]), // RULE8
      .fallEn    (edgeFallEn[e]),
      .risePulse (edgeRise[e]),
      .fallPulse (edgeFall[e])
    );
  end

  assign events            = edgeRise | edgeFall;
  assign extIrqInputE      = events[0];
  assign extIrqInputC      = events[1];
  assign extIrqInputB      = events[2];
  assign wideTimerCaptureA = edgeRise[3]; // RULE9
  assign wideTimerCaptureB = edgeFall[3];

  // dedicated pins outside the three ports
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      narrowPinOut    <= 2'h0;
      narrowPinOe     <= 2'h0;
      zeroCrossPinOut <= 2'h0;
      zeroCrossPinOe  <= pmx_pkg::RST_ZC_OE;
      rtcPinOut       <= 1'b0;
      rtcPinOe        <= pmx_pkg::RST_RTC_OE;
    end
    else
    begin
      narrowPinOut    <= narrowTimerOutput & misc_q.narrowEn;
      narrowPinOe     <= misc_q.narrowEn; // RULE10
      zeroCrossPinOut <= (zeroCrossIn & misc_q.zcEn) | (misc_q.lvLatch & ~misc_q.zcEn); // RULE11
      zeroCrossPinOe  <= pmx_pkg::RST_ZC_OE;
      rtcPinOut       <= misc_q.rtcSel ? rtcCorrection1hz : rtcClock32k; // RULE12
      rtcPinOe        <= pmx_pkg::RST_RTC_OE;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  chk_p1_dir_in: assert property ( // RULE1
    (!port1Ctrl_q[0] && port1DirectionBits_q[0]) |=> !padOe[0])
    else $error("port1 input pin is driven");
  chk_p3_pull_on: assert property ( // RULE2
    (!port3Ctrl_q[1] && port3DirectionBits_q[1] && port3PullupBits_q[1]) |=> padPullEn[12])
    else $error("port3 pull-up missing");
  chk_p2_dir_out: assert property ( // RULE3
    (!port2Analog_q[7] && !lcdSel[7] && !port2DirectionBits_q[7])
    |=> (padOe[10] && padOut[10] == $past(outLatch_q[10])))
    else $error("port2 output pin not driven from latch");
  chk_lcd_drive: assert property ( // RULE4
    (lcdSel[0] && !port2Analog_q[0]) |=> (padOe[3] && padOut[3] == $past(lcdSegmentOutputs[0])))
    else $error("lcd segment not on pin");
  chk_analog_reset: assert property ( // RULE5
    !seen_q |-> (port2Analog_q == pmx_pkg::RST_P2_ANALOG) ##1 (padOe[10:3] == 8'h00))
    else $error("port2 not analog after reset");
  chk_tx_select: assert property ( // RULE6
    (port1Ctrl_q[2] && port1FunctionSelect_q == pmx_pkg::PMX_TX_UART)
    |=> padOut[2] == $past(uartATransmit))
    else $error("uart transmit not on pin");
  chk_small_outonly: assert property ( // RULE7
    (!LARGE_PKG && !port1Ctrl_q[2]) |=> (padOe[2] && !padPullEn[2]))
    else $error("output-only pin released");
  chk_irq_edge: assert property ( // RULE8
    ($rose(pinSync[11]) && edgeCfg_q[0]) |=> ##1 irqStatus_q[0])
    else $error("rising edge not flagged");
  chk_capture_trig: assert property ( // RULE9
    $fell(pinSync[14]) |=> (wideTimerCaptureB && !wideTimerCaptureA))
    else $error("capture trigger missed");
  chk_narrow_hold: assert property ( // RULE10
    !misc_q.narrowEn[1] |=> !narrowPinOe[1])
    else $error("narrow timer pin left input state");
  chk_zc_latch: assert property ( // RULE11
    !misc_q.zcEn[0] |=> (zeroCrossPinOe[0] && zeroCrossPinOut[0] == $past(misc_q.lvLatch[0])))
    else $error("zero-cross pin not a port output");
  chk_rtc_out: assert property ( // RULE12
    !misc_q.rtcSel |=> (rtcPinOe && rtcPinOut == $past(rtcClock32k)))
    else $error("rtc clock not on pin");
  chk_serial_route: assert property ( // RULE13
    (port1Ctrl_q[2] && port1FunctionSelect_q == pmx_pkg::PMX_TX_SERIAL)
    |=> (padOe[2] && padOut[2] == $past(syncSerialDataOut)))
    else $error("serial data out not on pin");
  chk_ctrl_override: assert property ( // RULE14
    port1Ctrl_q[0] |=> (padOe[0] == $past(syncSerialClockOe)
                        && padOut[0] == $past(syncSerialClockOut)))
    else $error("peripheral drive not on pin");

endmodule // pmx_port_mux

// ### tb/pmx_pin_model.sv
module pmx_pin_model (
  input  wire logic [14:0] padOut,
  input  wire logic [14:0] padOe,
  input  wire logic [14:0] padPullEn,
  input  wire logic [14:0] extEn,
  input  wire logic [14:0] extLevel,
  output logic [14:0]      padIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // a pad with no driver and no pull-up shows the inverse, so stale levels never pass
  always_comb
    for (int i = 0; i < 15; i++)
      padIn[i] = padOe[i] ? padOut[i] : extEn[i] ? extLevel[i] :
                 padPullEn[i] ? 1'b1 : ~padOut[i];
endmodule // pmx_pin_model

// ### tb/tb_port1_to_port3_pin_mux.sv
module tb_port1_to_port3_pin_mux;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0]  paddr, analogInputSel, lcdSegmentOutputs;
  logic [31:0] pwdata, prdata, rdv, lat;
  logic [14:0] padIn, padOut, padOe, padPullEn, extEn, extLevel;
  logic        syncSerialClockOut, syncSerialClockOe, syncSerialClockIn, syncSerialDataIn;
  logic        syncSerialDataOut, uartAReceive, uartATransmit, infraredDataOut;
  logic        hTimerAOutput, hTimerBOutput, buzzerOutput, extIrqInputB, extIrqInputC;
  logic        extIrqInputE, wideTimerCountClk, wideTimerCaptureA, wideTimerCaptureB;
  logic        rtcClock32k, rtcCorrection1hz, rtcPinOut, rtcPinOe;
  logic [1:0]  narrowTimerOutput, narrowPinOut, narrowPinOe, zeroCrossIn;
  logic [1:0]  zeroCrossPinOut, zeroCrossPinOe;
  logic [21:0] per;
  int          mismatches, n_tests, regs[int];
  assign {syncSerialClockOut, syncSerialClockOe, syncSerialDataOut, uartATransmit,
          infraredDataOut, hTimerAOutput, hTimerBOutput, buzzerOutput, rtcClock32k,
          rtcCorrection1hz, lcdSegmentOutputs, narrowTimerOutput, zeroCrossIn} = per;
  pmx_port_mux #(.LARGE_PKG(1'b1)) pmx_port_mux_i (
    .mclk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .irq, .padIn, .padOut, .padOe, .padPullEn, .syncSerialClockOut, .syncSerialClockOe,
    .syncSerialClockIn, .syncSerialDataIn, .syncSerialDataOut, .uartAReceive, .uartATransmit,
    .infraredDataOut, .lcdSegmentOutputs, .analogInputSel, .hTimerAOutput, .hTimerBOutput,
    .buzzerOutput, .extIrqInputB, .extIrqInputC, .extIrqInputE, .wideTimerCountClk,
    .wideTimerCaptureA, .wideTimerCaptureB, .narrowTimerOutput, .narrowPinOut, .narrowPinOe,
    .zeroCrossIn, .zeroCrossPinOut, .zeroCrossPinOe, .rtcClock32k, .rtcCorrection1hz,
    .rtcPinOut, .rtcPinOe
  );
  pmx_pin_model pmx_pin_model_i (.padOut, .padOe, .padPullEn, .extEn, .extLevel, .padIn);

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic wrap_up();
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // checks land at the falling edge, after the design's own updates
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      mismatches++;
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdv, err);
    regs[a] = d;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rdv, err);
    chk($sformatf("reg %h", a), rdv, exp);
  endtask

  // pad 11 is the first external irq input; status bit 0 and irq follow its edges
  task automatic pulse(input logic lv, input logic ex);
    @(posedge mclk);
    extLevel[11] <= lv;
    tick(8);
    chk("irq", irq, ex);
    apb(1'b0, pmx_pkg::OFS_IRQ_STAT, 32'h0, rdv, err);
    chk("status", rdv[0], ex);
    wr(pmx_pkg::OFS_IRQ_CLR, 32'h1);
    tick(3);
    chk("irq cleared", irq, 1'b0);
  endtask

  initial
  begin
    #2000000;
    mismatches++;
    wrap_up();
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, per, extLevel, rst_b} = '0;
    extEn = 15'h7807;
    void'($urandom(43790));
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    tick(3);
    chk("analog sel", analogInputSel, 8'hFF);
    chk("narrow oe", narrowPinOe, 2'h0);
    chk("zero-cross oe", zeroCrossPinOe, 2'h3);
    chk("rtc pin", {rtcPinOe, rtcPinOut}, {1'b1, rtcClock32k});
    chk("pad oe", padOe, 15'h0000);
    rchk(pmx_pkg::OFS_P1_DIR, pmx_pkg::RST_P1_DIR);
    rchk(pmx_pkg::OFS_P2_DIR, pmx_pkg::RST_P2_DIR);
    rchk(pmx_pkg::OFS_P2_ANALOG, pmx_pkg::RST_P2_ANALOG);
    rchk(pmx_pkg::OFS_P3_DIR, pmx_pkg::RST_P3_DIR);
    rchk(pmx_pkg::OFS_EDGE_CFG, pmx_pkg::RST_EDGE_CFG);
    apb(1'b0, 8'hFC, 32'h0, rdv, err);
    chk("unmapped err", err, 1'b1);
    chk("unmapped", rdv, 32'h0);
    lat = $urandom & 32'h7FFF;
    wr(pmx_pkg::OFS_OUT_LATCH, lat);
    wr(pmx_pkg::OFS_P1_DIR, 32'h0);
    wr(pmx_pkg::OFS_P3_DIR, 32'h0);
    tick(3);
    chk("p1 out", {padOe[2:0], padOut[2:0]}, {3'h7, lat[2:0]});
    chk("p3 out", padOut[14:11], lat[14:11]);
    wr(pmx_pkg::OFS_P1_DIR, 32'h7);
    wr(pmx_pkg::OFS_P3_DIR, 32'hF);
    wr(pmx_pkg::OFS_P1_PULL, $urandom & 32'h7);
    wr(pmx_pkg::OFS_P3_PULL, $urandom & 32'hF);
    tick(3);
    chk("pull", padPullEn, {4'(regs[pmx_pkg::OFS_P3_PULL]), 8'h00,
        3'(regs[pmx_pkg::OFS_P1_PULL])});
    wr(pmx_pkg::OFS_P2_ANALOG, 32'h0);
    wr(pmx_pkg::OFS_P2_DIR, $urandom & 32'hFF);
    tick(3);
    chk("p2 oe", padOe[10:3], 8'(~regs[pmx_pkg::OFS_P2_DIR]));
    @(posedge mclk);
    per <= 22'($urandom);
    wr(pmx_pkg::OFS_P2_FUNC, 32'hFF);
    tick(3);
    chk("lcd", padOut[10:3], lcdSegmentOutputs);
    wr(pmx_pkg::OFS_P2_FUNC, 32'h0);
    wr(pmx_pkg::OFS_P1_CTRL, 32'h7);
    for (int s = 0; s < 4; s++)
    begin
      @(posedge mclk);
      per <= 22'($urandom);
      extLevel[1] <= 1'($urandom);
      wr(pmx_pkg::OFS_P1_FUNC, s);
      tick(4);
      chk("tx pin", {padOe[2], padOut[2]}, {1'b1, s == 1 ? uartATransmit :
          s == 2 ? infraredDataOut : syncSerialDataOut});
      chk("sck", {padOe[0], padOut[0]}, {syncSerialClockOe, syncSerialClockOut});
      chk("rx", {uartAReceive, syncSerialDataIn}, {2{extLevel[1]}});
    end
    wr(pmx_pkg::OFS_MISC, $urandom & 32'h7F);
    lat = regs[pmx_pkg::OFS_MISC];
    tick(3);
    chk("narrow", {narrowPinOe, narrowPinOut},
        {lat[1:0], lat[1:0] & narrowTimerOutput});
    chk("zero-cross", {zeroCrossPinOe, zeroCrossPinOut},
        {2'h3, (zeroCrossIn & lat[3:2]) | (lat[5:4] & ~lat[3:2])});
    chk("rtc", {rtcPinOe, rtcPinOut},
        {1'b1, lat[6] ? rtcCorrection1hz : rtcClock32k});
    wr(pmx_pkg::OFS_IRQ_EN, 32'h1);
    for (int m = 1; m < 4; m++)
    begin
      wr(pmx_pkg::OFS_EDGE_CFG, m);
      pulse(1'b1, m[0]);
      pulse(1'b0, m[1]);
    end
    // wide timer pin: capture a on rise, b on fall, status bit 3
    @(posedge mclk);
    extLevel[14] <= 1'b1;
    tick(3);
    chk("cap rise", {wideTimerCountClk, wideTimerCaptureA, wideTimerCaptureB},
        3'h6);
    @(posedge mclk);
    extLevel[14] <= 1'b0;
    tick(3);
    chk("cap fall", {wideTimerCountClk, wideTimerCaptureA, wideTimerCaptureB},
        3'h1);
    rchk(pmx_pkg::OFS_IRQ_STAT, 32'h8);
    wr(pmx_pkg::OFS_P3_CTRL, 32'hF);
    tick(3);
    chk("p3 ctrl", {padOe[14:11], padOut[14:12]},
        {4'hE, buzzerOutput, hTimerAOutput, hTimerBOutput});
    wrap_up();
  end
endmodule // tb_port1_to_port3_pin_mux
